// [timer3_pkg.sv]
// shared constants and types for the 8-bit timer three block
package timer3_pkg;
  localparam logic [2:0] ADDR_COMPARE = 3'h0;
  localparam logic [2:0] ADDR_SNAPSHOT = 3'h1;
  localparam logic [2:0] ADDR_CONTROL = 3'h2;
  localparam logic [2:0] ADDR_PORT_MUX = 3'h3;
  localparam logic [2:0] ADDR_REMOTE_RX = 3'h4;
  localparam logic [2:0] ADDR_IRQ_STATUS = 3'h5;
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h6;
  // control and port mux register fields
  localparam int CTL_CLK_LSB = 0;
  localparam int CTL_MODE_LSB = 3;
  localparam int CTL_START_BIT = 5;
  localparam int CTL_SNAP_BIT = 6;
  localparam int CTL_HALF_BIT = 7;
  localparam int PMX_POL_BIT = 0;
  localparam logic [1:0] MODE_TIMER = 2'h0;
  localparam logic [1:0] MODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_CAPTURE = 2'h2;
  localparam logic [7:0] SNAPSHOT_RESET = 8'hff;
  localparam logic [7:0] COMPARE_RESET = 8'hff;
  // code 000 divides by 2^13 of a 16 MHz reference; scaled to our clock
  localparam int SLOW_PERIOD_NS = 512000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int SLOW_DIV_CYCLES = SLOW_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PRESCALE_WIDTH = 16;
  localparam logic [2:0] CLK_SEL_FASTEST = 3'h6;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN} run_e;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  typedef struct packed {
    run_e run;
    logic [PRESCALE_WIDTH-1:0] prescale;
    logic [7:0] count;
    logic [7:0] compare;
    logic [7:0] snapshot;
    logic [7:0] control;
    logic [7:0] port_mux;
    logic [7:0] remote_rx;
    logic [7:0] filt_cnt;
    logic pin_filtered;
    logic pin_prev;
    logic [1:0] sync;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [7:0] rdata;
    logic irq;
  } state_s;
endpackage

// [timer3_counter_capture.sv]
// 8-bit timer three: timer, event counter and capture measurement
`timescale 1ns/1ps
`default_nettype none
module timer3_counter_capture
  import timer3_pkg::*;
#(
  parameter int SLOW_DIV = SLOW_DIV_CYCLES
)
(
  input wire logic clk, // system clock
  input wire logic resetn, // async reset, active low
  input wire timer3_pkg::bus_req_s bus, // register request
  output logic [7:0] rdata, // read data, cycle after strobe
  output logic timer_three_irq, // level interrupt
  input wire logic timer_three_input_pin // external pulse input
);
  state_s cur_ff;
  state_s nxt_ff;
  logic [PRESCALE_WIDTH-1:0] div_len;
  logic tick;
  logic pin_rise;
  logic pin_fall;
  logic pin_act;
  logic open_edge;
  logic close_edge;
  logic [1:0] mode;
  logic running;
  logic match_ev;
  logic cap_ev;
  logic [7:0] wr_ctl;
  logic [2:0] csel;
  logic status_wr;

  always_comb
  begin
    nxt_ff = cur_ff;
    mode = cur_ff.control[CTL_MODE_LSB +: 2];
    csel = cur_ff.control[CTL_CLK_LSB +: 3];
    if (csel > CLK_SEL_FASTEST)
    begin
      csel = CLK_SEL_FASTEST;
    end
    // each code up to 6 halves the period, 7 acts as 6; half option doubles it
    div_len = PRESCALE_WIDTH'(SLOW_DIV >> csel);
    if (cur_ff.control[CTL_HALF_BIT])
    begin
      div_len = PRESCALE_WIDTH'({div_len, 1'b0});
    end
    if (div_len == '0)
    begin
      div_len = PRESCALE_WIDTH'(1);
    end
    running = (cur_ff.run == ST_RUN);
    tick = running && (cur_ff.prescale >= div_len - PRESCALE_WIDTH'(1));

    // two-stage synchroniser; only the second stage is read downstream
    nxt_ff.sync = {cur_ff.sync[0], timer_three_input_pin};
    // capture mode passes the pin through a programmable glitch filter
    if (mode == MODE_CAPTURE)
    begin
      if (cur_ff.sync[1] == cur_ff.pin_filtered)
      begin
        nxt_ff.filt_cnt = 8'h00;
      end
      else if (cur_ff.filt_cnt >= cur_ff.remote_rx)
      begin
        nxt_ff.pin_filtered = cur_ff.sync[1];
        nxt_ff.filt_cnt = 8'h00;
      end
      else
      begin
        nxt_ff.filt_cnt = cur_ff.filt_cnt + 8'h01;
      end
    end
    else
    begin
      // outside capture the filter is bypassed
      nxt_ff.pin_filtered = cur_ff.sync[1];
      nxt_ff.filt_cnt = 8'h00;
    end
    nxt_ff.pin_prev = cur_ff.pin_filtered;
    pin_rise = cur_ff.pin_filtered && !cur_ff.pin_prev;
    pin_fall = !cur_ff.pin_filtered && cur_ff.pin_prev;
    // counting edge chosen by polarity bit
    pin_act = cur_ff.port_mux[PMX_POL_BIT] ? pin_fall : pin_rise;
    open_edge = cur_ff.port_mux[PMX_POL_BIT] ? pin_rise : pin_fall;
    close_edge = cur_ff.port_mux[PMX_POL_BIT] ? pin_fall : pin_rise;

    match_ev = 1'b0;
    cap_ev = 1'b0;
    // prescaler restarts whenever the counter is stopped
    if (tick)
    begin
      nxt_ff.prescale = '0;
    end
    else if (running)
    begin
      nxt_ff.prescale = cur_ff.prescale + PRESCALE_WIDTH'(1);
    end

    // counter state is only advanced while started
    if (running)
    begin
      case (mode)
        MODE_TIMER:
        begin
          // a compare of zero matches on every clock once started
          if (cur_ff.count == cur_ff.compare)
          begin
            match_ev = 1'b1;
            nxt_ff.count = 8'h00;
          end
          else if (tick)
          begin
            nxt_ff.count = cur_ff.count + 8'h01;
          end
        end
        MODE_EVENT:
        begin
          // match only checked on pin falling edge; a high pin holds off
          // when match and counting edge coincide, the match wins
          if (pin_fall && cur_ff.count == cur_ff.compare)
          begin
            match_ev = 1'b1;
            nxt_ff.count = 8'h00;
          end
          else if (pin_act)
          begin
            nxt_ff.count = cur_ff.count + 8'h01;
          end
        end
        MODE_CAPTURE:
        begin
          // free-running; width from open edge, period from close edge
          if (close_edge)
          begin
            nxt_ff.compare = cur_ff.count;
            nxt_ff.count = 8'h00;
            cap_ev = 1'b1;
          end
          else if (open_edge)
          begin
            nxt_ff.snapshot = cur_ff.count;
          end
          // saturate so an overlong phase reads as ff, never wraps
          if (!close_edge && tick && cur_ff.count != 8'hff)
          begin
            nxt_ff.count = cur_ff.count + 8'h01;
          end
        end
        default:
        begin
          nxt_ff.count = cur_ff.count;
        end
      endcase
    end
    else
    begin
      nxt_ff.count = 8'h00;
      nxt_ff.prescale = '0;
    end

    // read data is a one-cycle pulse; idle cycles read zero
    nxt_ff.rdata = 8'h00;
    if (bus.rd)
    begin
      case (bus.addr)
        ADDR_COMPARE:
        begin
          nxt_ff.rdata = cur_ff.compare;
        end
        ADDR_SNAPSHOT:
        begin
          nxt_ff.rdata = cur_ff.snapshot;
        end
        ADDR_CONTROL:
        begin
          nxt_ff.rdata = cur_ff.control;
        end
        ADDR_PORT_MUX:
        begin
          nxt_ff.rdata = cur_ff.port_mux;
        end
        ADDR_REMOTE_RX:
        begin
          nxt_ff.rdata = cur_ff.remote_rx;
        end
        ADDR_IRQ_STATUS:
        begin
          nxt_ff.rdata = {6'h00, cur_ff.irq_status};
        end
        ADDR_IRQ_MASK:
        begin
          nxt_ff.rdata = {6'h00, cur_ff.irq_mask};
        end
        default:
        begin
          nxt_ff.rdata = 8'h00;
        end
      endcase
    end

    wr_ctl = bus.wdata;
    if (bus.wr)
    begin
      case (bus.addr)
        ADDR_COMPARE:
        begin
          nxt_ff.compare = bus.wdata;
        end
        ADDR_CONTROL:
        begin
          // snapshot is a strobe, never stored; stopping clears counter
          nxt_ff.control = {wr_ctl[7], 1'b0, wr_ctl[5:0]};
          nxt_ff.run = wr_ctl[CTL_START_BIT] ? ST_RUN : ST_IDLE;
          // copy is asynchronous to the prescaler tick
          if (wr_ctl[CTL_SNAP_BIT] && mode != MODE_CAPTURE)
          begin
            nxt_ff.snapshot = cur_ff.count;
          end
        end
        ADDR_PORT_MUX:
        begin
          nxt_ff.port_mux = {7'h00, bus.wdata[PMX_POL_BIT]};
        end
        ADDR_REMOTE_RX:
        begin
          nxt_ff.remote_rx = bus.wdata;
        end
        ADDR_IRQ_MASK:
        begin
          nxt_ff.irq_mask = bus.wdata[1:0];
        end
        default:
        begin
          nxt_ff.run = cur_ff.run;
        end
      endcase
    end

    // write-one-to-clear; a same-cycle event wins over the clear
    status_wr = bus.wr && (bus.addr == ADDR_IRQ_STATUS);
    if (status_wr)
    begin
      nxt_ff.irq_status = cur_ff.irq_status & ~bus.wdata[1:0];
    end
    nxt_ff.irq_status = nxt_ff.irq_status | {cap_ev, match_ev};
    nxt_ff.irq = |(nxt_ff.irq_status & nxt_ff.irq_mask);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      // compare and snapshot come up all ones; the rest is cleared
      cur_ff <= '{run: ST_IDLE,
                  prescale: '0,
                  count: 8'h00,
                  compare: COMPARE_RESET,
                  snapshot: SNAPSHOT_RESET,
                  control: 8'h00,
                  port_mux: 8'h00,
                  remote_rx: 8'h00,
                  filt_cnt: 8'h00,
                  pin_filtered: 1'b0,
                  pin_prev: 1'b0,
                  sync: 2'h0,
                  irq_status: 2'h0,
                  irq_mask: 2'h0,
                  rdata: 8'h00,
                  irq: 1'b0};
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  assign rdata = cur_ff.rdata;
  assign timer_three_irq = cur_ff.irq;
endmodule // timer3_counter_capture
`default_nettype wire

// [timer3_sva.sv]
// assertion checker for the timer three block
`timescale 1ns/1ps
`default_nettype none
module timer3_sva
  import timer3_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic resetn, // async reset, active low
  input wire bus_req_s bus, // register request
  input wire logic [7:0] rdata, // read data
  input wire logic timer_three_irq, // level interrupt
  input wire logic timer_three_input_pin // pulse input
);
  logic [7:0] cmp_ff;
  logic [1:0] mask_ff;
  logic [1:0] mode_ff;
  logic start_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // shadows of software writes; capture mode overwrites compare itself
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      {cmp_ff, mask_ff, mode_ff, start_ff} <= 13'h1fe0;
    else if (bus.wr && bus.addr == ADDR_COMPARE)
      cmp_ff <= bus.wdata;
    else if (bus.wr && bus.addr == ADDR_IRQ_MASK)
      mask_ff <= bus.wdata[1:0];
    else if (bus.wr && bus.addr == ADDR_CONTROL)
      {mode_ff, start_ff} <= {bus.wdata[4:3], bus.wdata[5]};
  sequence s_rd(logic [2:0] a);
    bus.rd && bus.addr == a;
  endsequence
  a_rdata_idle: assert property (!bus.rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (s_rd(3'h7) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_snap_reads_zero: assert property (
    s_rd(ADDR_CONTROL) |=> !rdata[CTL_SNAP_BIT])
    else $error("snapshot strobe reads back set");
  a_compare_readback: assert property (
    s_rd(ADDR_COMPARE) ##0 mode_ff != MODE_CAPTURE |=> rdata == $past(cmp_ff))
    else $error("compare readback differs");
  a_mask_readback: assert property (
    s_rd(ADDR_IRQ_MASK) |=> rdata[1:0] == $past(mask_ff))
    else $error("mask readback differs");
  a_irq_masked: assert property (mask_ff == 2'h0 |-> !timer_three_irq)
    else $error("interrupt high while fully masked");
  a_event_fall: assert property (
    $rose(timer_three_irq) && mode_ff == MODE_EVENT && $stable(mask_ff)
    |-> !$past(timer_three_input_pin, 2))
    else $error("event match without falling pin");
  a_stop_quiet: assert property (
    $rose(timer_three_irq) |-> start_ff || $past(start_ff) || $changed(mask_ff))
    else $error("interrupt raised while stopped");
endmodule // timer3_sva
bind timer3_counter_capture timer3_sva chk (.clk(clk), .resetn(resetn),
  .bus(bus), .rdata(rdata), .timer_three_irq(timer_three_irq),
  .timer_three_input_pin(timer_three_input_pin));
`default_nettype wire

// [pulse_source.sv]
// model of the external pulse source driving the input pin
`timescale 1ns/1ps
`default_nettype none
module pulse_source
(
  input wire logic clk, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic run, // toggle while high, hold level while low
  input wire logic [7:0] half, // clocks per phase, four or more
  output logic pin // pulse output
);
  logic [7:0] cnt_ff;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      {pin, cnt_ff} <= 9'h000;
    else if (run && cnt_ff >= half - 8'h01)
      {pin, cnt_ff} <= {~pin, 8'h00};
    else if (run)
      cnt_ff <= cnt_ff + 8'h01;
endmodule // pulse_source
`default_nettype wire

// [tb_timer3_counter_capture.sv]
// testbench for the timer three block
`timescale 1ns/1ps
`default_nettype none
module tb_timer3_counter_capture;
  import timer3_pkg::*;
  localparam int SLOW_DIV = 256;
  localparam logic [3:0] CFG [3] = '{4'h6, 4'he, 4'h5};
  logic clk, resetn, irq, pin, run;
  logic [7:0] rdata, half;
  bus_req_s bus;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  int n, p;
  timer3_counter_capture #(.SLOW_DIV(SLOW_DIV)) dut (.clk(clk),
    .resetn(resetn), .bus(bus), .rdata(rdata), .timer_three_irq(irq),
    .timer_three_input_pin(pin));
  pulse_source src (.clk(clk), .resetn(resetn), .run(run), .half(half),
    .pin(pin));
  always #25 clk = ~clk;
  task automatic tally_and_finish();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, lo, hi);
    compares++;
    if ((seen >= lo && seen <= hi) !== 1'b1)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h..%h", $time, seen, lo, hi);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] lo, hi);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 check(rdata, lo, hi);
    @(posedge clk);
  endtask
  // bounded wait; the count doubles as a latency measurement
  task automatic wait_irq(output int cnt);
    cnt = 0;
    while (irq !== 1'b1 && cnt < 300)
      @(posedge clk) #1 cnt++;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial
  begin
    clk = 1'b0;
    resetn = 1'b0;
    bus = '0;
    run = 1'b0;
    half = 8'h06;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(ADDR_COMPARE, 8'hff, 8'hff);
    rd(ADDR_SNAPSHOT, 8'hff, 8'hff);
    rd(3'h7, 8'h00, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h03);
    rd(ADDR_IRQ_MASK, 8'h03, 8'h03);
    for (int i = 0; i < 3; i++)
    begin
      p = (SLOW_DIV >> CFG[i][2:0]) << CFG[i][3];
      wr(ADDR_COMPARE, 8'h03);
      wr(ADDR_CONTROL, {CFG[i][3], 4'h4, CFG[i][2:0]});
      wait_irq(n);
      check(n[7:0], 8'(3 * p - 2), 8'(4 * p + 4));
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_IRQ_STATUS, 8'h01);
    end
    repeat (40) @(posedge clk);
    check({7'h00, irq}, 8'h00, 8'h00);
    rd(ADDR_IRQ_STATUS, 8'h00, 8'h00);
    wr(ADDR_PORT_MUX, 8'h00);
    wr(ADDR_CONTROL, 8'h28);
    run <= 1'b1;
    repeat (3) @(posedge pin);
    run <= 1'b0;
    repeat (12) @(posedge clk);
    check({7'h00, irq}, 8'h00, 8'h00);
    wr(ADDR_CONTROL, 8'h68);
    rd(ADDR_SNAPSHOT, 8'h03, 8'h03);
    rd(ADDR_CONTROL, 8'h28, 8'h28);
    run <= 1'b1;
    wait_irq(n);
    run <= 1'b0;
    check({7'h00, irq}, 8'h01, 8'h01);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_IRQ_STATUS, 8'h03);
    half <= 8'h28;
    wr(ADDR_CONTROL, 8'h36);
    run <= 1'b1;
    wait_irq(n);
    rd(ADDR_SNAPSHOT, 8'h03, 8'h03);
    rd(ADDR_IRQ_STATUS, 8'h02, 8'h02);
    wr(ADDR_IRQ_STATUS, 8'h02);
    wait_irq(n);
    rd(ADDR_COMPARE, 8'h13, 8'h15);
    rd(ADDR_SNAPSHOT, 8'h09, 8'h0b);
    // inverted polarity with the noise filter on; first edge is partial
    wr(ADDR_PORT_MUX, 8'h01);
    wr(ADDR_REMOTE_RX, 8'h05);
    wr(ADDR_IRQ_STATUS, 8'h02);
    wait_irq(n);
    wr(ADDR_IRQ_STATUS, 8'h02);
    wait_irq(n);
    rd(ADDR_COMPARE, 8'h13, 8'h15);
    rd(ADDR_SNAPSHOT, 8'h09, 8'h0b);
    wr(ADDR_IRQ_MASK, 8'h00);
    #1 check({7'h00, irq}, 8'h00, 8'h00);
    tally_and_finish();
  end
endmodule // tb_timer3_counter_capture
`default_nettype wire
